// >>> logic/hsspl_pkg.sv
// Purpose: Shared constants for the hub strap and status pin logic
// Assumes: One clock, asynchronous active-low reset
// Notes:   Reset values of captured straps follow the pin pull defaults
`default_nettype none
package hsspl_pkg;
   localparam int unsigned NUM_PORTS      = 4;
   localparam int unsigned SYNC_STAGES    = 2;
   // Strap defaults while reset is held (pull-up / pull-down levels)
   localparam logic        RST_MODE_I2C   = 1'h1;
   localparam logic        RST_POLARITY   = 1'h1;
   localparam logic        RST_GANGED     = 1'h0;
   localparam logic        RST_CFG0       = 1'h0;
   localparam logic        RST_CFG1       = 1'h0;
   // Field positions in the two-bit descriptor configured field
   localparam int unsigned CFG_BIT0_POS   = 0;
   localparam int unsigned CFG_BIT1_POS   = 1;
endpackage : hsspl_pkg
`default_nettype wire

// >>> logic/hsspl_strap_status.sv
// Purpose: Strap capture and status output muxing of multifunction pins
// Assumes: Pins are asynchronous and pass a two-stage synchroniser
// Notes:   Straps are captured once the synchronisers fill after release
`default_nettype none
module hsspl_strap_status #(
   parameter int unsigned PORTS = hsspl_pkg::NUM_PORTS
) (
   // Clock and reset
   input  wire logic             CLK_I,
   input  wire logic             ARST_N_I,
   // Strap and multifunction pins
   input  wire logic             INTERFACE_MODE_SELECT_PIN_I,
   input  wire logic             POWER_POLARITY_STRAP_I,
   input  wire logic             BILLBOARD_ON_PIN_I,
   output var  logic             BILLBOARD_ON_PIN_O,
   output var  logic             BILLBOARD_ON_PIN_OE_O,
   input  wire logic             DESCRIPTOR_CFG_BIT0_PIN_I,
   output var  logic             DESCRIPTOR_CFG_BIT0_PIN_O,
   output var  logic             DESCRIPTOR_CFG_BIT0_PIN_OE_O,
   input  wire logic             DESCRIPTOR_CFG_BIT1_PIN_I,
   output var  logic             DESCRIPTOR_CFG_BIT1_PIN_O,
   output var  logic             DESCRIPTOR_CFG_BIT1_PIN_OE_O,
   // Hub state and register bits
   input  wire logic             STATUS_OUTPUT_ENABLE_BIT_I,
   input  wire logic             BILLBOARD_ENABLE_BIT_I,
   input  wire logic [1:0]       DESCRIPTOR_CONFIGURED_REG_I,
   input  wire logic             CHARGING_ENABLED_ANY_I,
   input  wire logic             UPSTREAM_HIGHSPEED_I,
   input  wire logic             UPSTREAM_SUPERSPEED_I,
   input  wire logic             UPSTREAM_HS_SLEEP_I,
   input  wire logic [PORTS-1:0] PORT_POWER_ON_I,
   // Port power and configuration results
   output var  logic [PORTS-1:0] PORT_POWER_SWITCH_OUT_O,
   output var  logic             I2C_MODE_O,
   output var  logic             BILLBOARD_ENABLE_O,
   output var  logic [1:0]       DESCRIPTOR_CONFIGURED_FIELD_O,
   output var  logic             GANGED_POWER_STRAP_O,
   output var  logic             FULL_AUTOMATIC_STRAP_N_O,
   output var  logic             FULL_AUTOMATIC_LOAD_O,
   output var  logic             POWER_SWITCH_SUPPORT_STRAP_N_O,
   output var  logic             AUTOMATIC_MODE_STRAP_N_O
);

   typedef struct packed {
      logic [1:0]       mode_sync;
      logic [1:0]       pol_sync;
      logic [1:0]       bb_sync;
      logic [1:0]       c0_sync;
      logic [1:0]       c1_sync;
      logic             captured;
      logic [1:0]       fill;
      logic             i2c_mode;
      logic             polarity;
      logic             ganged;
      logic             cfg0;
      logic             cfg1;
      logic             load;
      logic             bb_o;
      logic             bb_oe;
      logic             c0_o;
      logic             c0_oe;
      logic             c1_o;
      logic             c1_oe;
      logic             bb_en;
      logic [1:0]       field;
      logic [PORTS-1:0] pwr;
   } hsspl_state_s;

   hsspl_state_s st_q;
   hsspl_state_s st_d;

   // Sync stages hold reset zeros until this many edges have passed
   localparam logic [1:0] FILL_DONE = 2'(hsspl_pkg::SYNC_STAGES);

   // Status drive only outside I2C mode and only after capture
   function automatic logic status_drive(input hsspl_state_s s,
                                         input logic en);
      return s.captured && !s.i2c_mode && en;
   endfunction

   always_comb
   begin
      st_d           = st_q;
      // Second stage reads only the first stage
      st_d.mode_sync = {st_q.mode_sync[0], INTERFACE_MODE_SELECT_PIN_I};
      st_d.pol_sync  = {st_q.pol_sync[0], POWER_POLARITY_STRAP_I};
      st_d.bb_sync   = {st_q.bb_sync[0], BILLBOARD_ON_PIN_I};
      st_d.c0_sync   = {st_q.c0_sync[0], DESCRIPTOR_CFG_BIT0_PIN_I};
      st_d.c1_sync   = {st_q.c1_sync[0], DESCRIPTOR_CFG_BIT1_PIN_I};
      st_d.load      = 1'h0;
      if (!st_q.captured && st_q.fill != FILL_DONE)
      begin
         // Capturing now would read reset zeros, always SMBus mode
         st_d.fill = st_q.fill + 2'h1;
      end
      else if (!st_q.captured)
      begin
         // One-time capture; held until the next reset
         st_d.captured = 1'h1;
         st_d.i2c_mode = st_q.mode_sync[1];
         st_d.polarity = st_q.pol_sync[1];
         st_d.ganged   = st_q.bb_sync[1];
         st_d.cfg0     = st_q.c0_sync[1];
         st_d.cfg1     = st_q.c1_sync[1];
         st_d.load     = !st_q.mode_sync[1] &&
                         CHARGING_ENABLED_ANY_I;
      end
      // Pins stay inputs until the straps are held
      st_d.bb_oe = status_drive(st_d, STATUS_OUTPUT_ENABLE_BIT_I);
      st_d.c0_oe = st_d.bb_oe;
      st_d.c1_oe = st_d.bb_oe;
      st_d.bb_o  = st_d.bb_oe && UPSTREAM_HIGHSPEED_I;
      st_d.c0_o  = st_d.c0_oe && UPSTREAM_SUPERSPEED_I;
      st_d.c1_o  = st_d.c1_oe && UPSTREAM_HS_SLEEP_I;
      if (st_d.i2c_mode)
      begin
         // Live pin levels; synchronised copies only
         st_d.bb_en = st_q.bb_sync[1];
         st_d.field = {st_q.c1_sync[1], st_q.c0_sync[1]};
      end
      else
      begin
         st_d.bb_en = BILLBOARD_ENABLE_BIT_I;
         st_d.field = DESCRIPTOR_CONFIGURED_REG_I;
      end
      // Polarity applied to every port output
      st_d.pwr = st_d.polarity ? PORT_POWER_ON_I : ~PORT_POWER_ON_I;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         st_q          <= '0;
         st_q.i2c_mode <= hsspl_pkg::RST_MODE_I2C;
         st_q.polarity <= hsspl_pkg::RST_POLARITY;
         st_q.ganged   <= hsspl_pkg::RST_GANGED;
         st_q.cfg0     <= hsspl_pkg::RST_CFG0;
         st_q.cfg1     <= hsspl_pkg::RST_CFG1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign BILLBOARD_ON_PIN_O             = st_q.bb_o;
   assign BILLBOARD_ON_PIN_OE_O          = st_q.bb_oe;
   assign DESCRIPTOR_CFG_BIT0_PIN_O      = st_q.c0_o;
   assign DESCRIPTOR_CFG_BIT0_PIN_OE_O   = st_q.c0_oe;
   assign DESCRIPTOR_CFG_BIT1_PIN_O      = st_q.c1_o;
   assign DESCRIPTOR_CFG_BIT1_PIN_OE_O   = st_q.c1_oe;
   assign PORT_POWER_SWITCH_OUT_O        = st_q.pwr;
   assign I2C_MODE_O                     = st_q.i2c_mode;
   assign BILLBOARD_ENABLE_O             = st_q.bb_en;
   assign DESCRIPTOR_CONFIGURED_FIELD_O  = st_q.field;
   assign GANGED_POWER_STRAP_O           = st_q.ganged;
   assign FULL_AUTOMATIC_STRAP_N_O       = st_q.cfg0;
   assign FULL_AUTOMATIC_LOAD_O          = st_q.load;
   assign POWER_SWITCH_SUPPORT_STRAP_N_O = st_q.cfg0;
   assign AUTOMATIC_MODE_STRAP_N_O       = st_q.cfg1;

   property p_capture_once;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      $past(st_q.captured) |-> $stable(st_q.i2c_mode) &&
         $stable(st_q.polarity) && $stable(st_q.ganged) &&
         $stable(st_q.cfg0) && $stable(st_q.cfg1);
   endproperty
   a_capture_once: assert property (p_capture_once)
      else $error("strap changed after capture");

   property p_mode_sample;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      $rose(st_q.captured) |->
         I2C_MODE_O == $past(INTERFACE_MODE_SELECT_PIN_I, 3);
   endproperty
   a_mode_sample: assert property (p_mode_sample)
      else $error("mode not sampled from pin");

   property p_polarity;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      st_q.captured |=> PORT_POWER_SWITCH_OUT_O ==
         ($past(st_q.polarity) ? $past(PORT_POWER_ON_I)
                               : ~$past(PORT_POWER_ON_I));
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("power output polarity wrong");

   property p_i2c_bb;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      st_q.captured && st_q.i2c_mode |=>
         BILLBOARD_ENABLE_O == $past(BILLBOARD_ON_PIN_I, 3) &&
         DESCRIPTOR_CONFIGURED_FIELD_O ==
            {$past(DESCRIPTOR_CFG_BIT1_PIN_I, 3),
             $past(DESCRIPTOR_CFG_BIT0_PIN_I, 3)};
   endproperty
   a_i2c_bb: assert property (p_i2c_bb)
      else $error("i2c billboard not from pins");

   property p_smb_bb;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      st_q.captured && !st_q.i2c_mode |=>
         BILLBOARD_ENABLE_O == $past(BILLBOARD_ENABLE_BIT_I) &&
         DESCRIPTOR_CONFIGURED_FIELD_O == $past(DESCRIPTOR_CONFIGURED_REG_I);
   endproperty
   a_smb_bb: assert property (p_smb_bb)
      else $error("smbus billboard not from register");

   sequence s_status_on;
      st_q.captured && !st_q.i2c_mode && STATUS_OUTPUT_ENABLE_BIT_I;
   endsequence
   property p_status_drive;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      s_status_on |=> BILLBOARD_ON_PIN_OE_O &&
         DESCRIPTOR_CFG_BIT0_PIN_OE_O &&
         DESCRIPTOR_CFG_BIT1_PIN_OE_O &&
         BILLBOARD_ON_PIN_O == $past(UPSTREAM_HIGHSPEED_I) &&
         DESCRIPTOR_CFG_BIT0_PIN_O == $past(UPSTREAM_SUPERSPEED_I) &&
         DESCRIPTOR_CFG_BIT1_PIN_O == $past(UPSTREAM_HS_SLEEP_I);
   endproperty
   a_status_drive: assert property (p_status_drive)
      else $error("status pins not driven");

   property p_inputs_before;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      !st_q.captured || st_q.i2c_mode |-> !BILLBOARD_ON_PIN_OE_O &&
         !DESCRIPTOR_CFG_BIT0_PIN_OE_O && !DESCRIPTOR_CFG_BIT1_PIN_OE_O;
   endproperty
   a_inputs_before: assert property (p_inputs_before)
      else $error("pin driven before capture or in i2c");

   // Pin level three edges back: two sync stages plus the capture edge
   sequence s_strap_taken;
      GANGED_POWER_STRAP_O == $past(BILLBOARD_ON_PIN_I, 3) &&
      FULL_AUTOMATIC_STRAP_N_O == $past(DESCRIPTOR_CFG_BIT0_PIN_I, 3) &&
      POWER_SWITCH_SUPPORT_STRAP_N_O == $past(DESCRIPTOR_CFG_BIT0_PIN_I, 3) &&
      AUTOMATIC_MODE_STRAP_N_O == $past(DESCRIPTOR_CFG_BIT1_PIN_I, 3) &&
      FULL_AUTOMATIC_LOAD_O ==
         (!I2C_MODE_O && $past(CHARGING_ENABLED_ANY_I));
   endsequence
   property p_straps;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      $rose(st_q.captured) |-> s_strap_taken ##1 !FULL_AUTOMATIC_LOAD_O;
   endproperty
   a_straps: assert property (p_straps)
      else $error("strap capture wrong");

endmodule : hsspl_strap_status
`default_nettype wire

// >>> verif/hsspl_board_model.sv
// Purpose: Board straps with pull levels on the shared hub pins
// Assumes: Hub drive overrides the strap resistors
// Notes:   Enables are high while the hub drives a pin
`default_nettype none
module hsspl_board_model (
   // Strap levels fitted on the board
   input  wire logic mode_i, pol_i, bb_i, c0_i, c1_i,
   // Hub side of the shared pins
   input  wire logic bb_d_i, bb_oe_i, c0_d_i, c0_oe_i, c1_d_i, c1_oe_i,
   // Resolved pin levels
   output logic      mode_o, pol_o, bb_o, c0_o, c1_o
);
   timeunit 1ns;
   timeprecision 100ps;
   assign mode_o = mode_i;
   assign pol_o  = pol_i;
   // Resistor only sets the level while the hub is not driving
   assign bb_o   = bb_oe_i ? bb_d_i : bb_i;
   assign c0_o   = c0_oe_i ? c0_d_i : c0_i;
   assign c1_o   = c1_oe_i ? c1_d_i : c1_i;
endmodule // hsspl_board_model
`default_nettype wire

// >>> verif/hsspl_strap_status_tb.sv
// Purpose: Self-checking bench for strap capture and status pins
// Assumes: Board model resolves the three shared pins
// Notes:   One reset per row; hand tests follow the loop
`default_nettype none
module hsspl_strap_status_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic       mode, pol, bb, c0, c1, sts, chg;
      logic [3:0] pwr;
      logic       ld;
   } hsspl_row_s;
   hsspl_row_s rows [6] = '{12'hF0A, 12'h8F4, 12'h6CA, 12'h175, 12'h5AB,
                            12'h214};
   hsspl_row_s r;
   logic       clk, arst_n, m_s, p_s, b_s, c0_s, c1_s, sts, bbe, chg;
   logic       hs, ss, sl;
   logic [1:0] dreg;
   logic [3:0] pwr_on;
   wire logic  m_p, p_p, b_p, c0_p, c1_p, b_o, b_oe, c0_o, c0_oe, c1_o;
   wire logic  c1_oe, i2c, bb_en, gang, fa_n, ld, ps_n, am_n;
   wire logic [3:0] pwr_out;
   wire logic [1:0] fld;
   int         bad_count = 0;
   int         tests_run = 0;
   int         ld_cnt = 0;

   hsspl_strap_status i_hsspl_strap_status (.CLK_I(clk), .ARST_N_I(arst_n),
      .INTERFACE_MODE_SELECT_PIN_I(m_p), .POWER_POLARITY_STRAP_I(p_p),
      .BILLBOARD_ON_PIN_I(b_p), .BILLBOARD_ON_PIN_O(b_o),
      .BILLBOARD_ON_PIN_OE_O(b_oe), .DESCRIPTOR_CFG_BIT0_PIN_I(c0_p),
      .DESCRIPTOR_CFG_BIT0_PIN_O(c0_o), .DESCRIPTOR_CFG_BIT0_PIN_OE_O(c0_oe),
      .DESCRIPTOR_CFG_BIT1_PIN_I(c1_p), .DESCRIPTOR_CFG_BIT1_PIN_O(c1_o),
      .DESCRIPTOR_CFG_BIT1_PIN_OE_O(c1_oe), .STATUS_OUTPUT_ENABLE_BIT_I(sts),
      .BILLBOARD_ENABLE_BIT_I(bbe), .DESCRIPTOR_CONFIGURED_REG_I(dreg),
      .CHARGING_ENABLED_ANY_I(chg), .UPSTREAM_HIGHSPEED_I(hs),
      .UPSTREAM_SUPERSPEED_I(ss), .UPSTREAM_HS_SLEEP_I(sl),
      .PORT_POWER_ON_I(pwr_on), .PORT_POWER_SWITCH_OUT_O(pwr_out),
      .I2C_MODE_O(i2c), .BILLBOARD_ENABLE_O(bb_en),
      .DESCRIPTOR_CONFIGURED_FIELD_O(fld), .GANGED_POWER_STRAP_O(gang),
      .FULL_AUTOMATIC_STRAP_N_O(fa_n), .FULL_AUTOMATIC_LOAD_O(ld),
      .POWER_SWITCH_SUPPORT_STRAP_N_O(ps_n), .AUTOMATIC_MODE_STRAP_N_O(am_n));
   hsspl_board_model i_hsspl_board_model (.mode_i(m_s), .pol_i(p_s),
      .bb_i(b_s), .c0_i(c0_s), .c1_i(c1_s), .bb_d_i(b_o), .bb_oe_i(b_oe),
      .c0_d_i(c0_o), .c0_oe_i(c0_oe), .c1_d_i(c1_o), .c1_oe_i(c1_oe),
      .mode_o(m_p), .pol_o(p_p), .bb_o(b_p), .c0_o(c0_p), .c1_o(c1_p));

   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // Pulse cycles since the last reset
   always @(posedge clk)
      if (!arst_n) ld_cnt <= 0;
      else if (ld === 1'h1) ld_cnt <= ld_cnt + 1;

   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'h1)
      begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Straps stay put across release; capture reads synchronised pins
   task automatic do_reset(input hsspl_row_s x);
      @(posedge clk);
      arst_n <= 1'h0;
      {m_s, p_s, b_s, c0_s, c1_s, sts, chg} <= x[11:5];
      // Register bits differ from the pins so the source shows
      {bbe, dreg, hs, ss, sl, pwr_on} <= {~x.bb, ~x.c1, ~x.c0, 3'h5, 4'h5};
      repeat (12) @(posedge clk);
      arst_n <= 1'h1;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask

   initial
   begin
      {arst_n, m_s, p_s, b_s, c0_s, c1_s, sts, bbe, chg, hs, ss, sl} = '0;
      {dreg, pwr_on} = '0;
      foreach (rows[i])
      begin
         r = rows[i];
         do_reset(r);
         chk(i2c === r.mode, "mode strap");
         chk(pwr_out === r.pwr, "power polarity");
         chk(ld_cnt == int'(r.ld), "load pulse");
         if (r.mode)
         begin
            chk({bb_en, fld} === {r.bb, r.c1, r.c0}, "pins");
            chk({b_oe, c0_oe, c1_oe} === 3'h0, "inputs");
         end
         else
         begin
            chk({bb_en, fld} === ~{r.bb, r.c1, r.c0},
                "reg bits");
            chk(gang === r.bb, "ganged");
            chk({fa_n, ps_n} === {2{r.c0}}, "cfg0 strap");
            chk(am_n === r.c1, "cfg1 strap");
            chk({b_oe, c0_oe, c1_oe} === {3{r.sts}}, "oe");
            if (r.sts)
               chk({b_o, c0_o, c1_o} === 3'h5, "status");
         end
         // Late strap changes must not reach captured values
         @(posedge clk);
         {m_s, p_s, b_s, c0_s, c1_s} <= ~{r.mode, r.pol, r.bb, r.c0, r.c1};
         {hs, ss, sl} <= 3'h2;
         repeat (4) @(posedge clk);
         @(negedge clk);
         chk({i2c, pwr_out} === {r.mode, r.pwr}, "held");
         if (r.mode)
            chk({bb_en, fld} === ~{r.bb, r.c1, r.c0}, "follow");
         else
            chk({gang, am_n, ps_n} === {r.bb, r.c1, r.c0}, "held");
         if (!r.mode && r.sts)
            chk({b_o, c0_o, c1_o} === 3'h2, "status");
      end
      do_reset(rows[2]);
      @(posedge clk);
      {sts, chg} <= 2'h1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({b_oe, c0_oe, c1_oe} === 3'h0, "oe off");
      chk(ld_cnt == 0, "late charge");
      @(posedge clk);
      arst_n <= 1'h0;
      @(negedge clk);
      chk({b_oe, c0_oe, c1_oe, i2c, pwr_out} === 8'h10, "reset");
      do_reset(rows[3]);
      chk(ld_cnt == 1, "second release");
      test_done();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      $display("unexpected at %0t: watchdog", $time);
      test_done();
   end
endmodule // hsspl_strap_status_tb
`default_nettype wire
